// ==== src/sri_exec.sv ====
// execution unit for or, stack pull/store, exit, carry clear and rotates
// Functional notes
// - each flag computed, kept, cleared, set
// - or 48/49 sets Z S, clears V
// - pull loads from stack, then pointer+1
// - store: pointer-1 first, then write source
// - exit loads PC from stack, pointer+2
// - rotate left: bit7 into bit0, carry
// - rotate left via carry: carry into bit0
// - rotate right: bit0 into bit7, carry
// - rotate right via carry: carry into bit7
`timescale 1ns/1ps
`include "sri_params.svh"
module sri_exec #(
   parameter int PTR_W = 12, // stack pointer width
   parameter int PC_W = 16 // program counter width
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instrValid, // fetch offers an instruction
   input sri_pkg::sri_instr_type instr, // opcode plus operands
   input wire logic [7:0] stackLo, // byte at stack pointer
   input wire logic [7:0] stackHi, // byte at stack pointer + 1
   output logic instrReady, // executor can take an instruction
   output logic illegalOp, // offered opcode not handled here
   output sri_pkg::sri_wr_type wrPort, // write to register file/memory
   output logic [PTR_W-1:0] stackPtr, // current stack pointer
   output logic [PC_W-1:0] pcLoad, // new program counter
   output logic pcLoadEn, // pcLoad valid, one cycle
   output logic [7:0] flags, // C Z S V in bits 7..4
   output logic [2:0] instrBytes, // length of the finished instruction
   output logic done // instruction retired, one cycle
);
   import sri_pkg::*;

   // decode, sequencing and latched operand state
   sri_dec_type dec; // decode of the offered opcode
   sri_state_type state_ff, nxt_state; // sequencer
   sri_op_type op_ff; // latched operation
   logic [2:0] cnt_ff; // remaining execute cycles
   logic [2:0] len_ff; // latched length
   sri_instr_type ins_ff; // latched operands
   logic [PTR_W-1:0] stkPtr_ff; // stack pointer
   logic [7:0] flags_ff; // status flags
   // combinational datapath results
   logic [7:0] res; // result byte
   logic resC; // result carry
   logic take; // instruction accepted
   logic lastCyc; // final execute cycle

   // opcode decode
   // decoder is purely combinational on the offered opcode
   // it only classifies; all state lives in this module
   sri_decode u_dec (
      .opcode(instr.opcode),
      .dec(dec)
   );

   // ready only while idle, so a new opcode
   // cannot be taken mid-instruction
   assign instrReady = (state_ff == SRI_IDLE);
   // legal opcodes only; anything else pulses illegalOp
   assign take = instrValid && instrReady && dec.legal;
   // last execute cycle, when results are committed
   assign lastCyc = (state_ff == SRI_EXEC) && (cnt_ff == 3'd1);

   // next state
   // idle waits for a legal offer, exec counts down,
   // done lasts one cycle and returns to idle
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SRI_IDLE: if (take) nxt_state = SRI_EXEC;
         SRI_EXEC: if (cnt_ff == 3'd1) nxt_state = SRI_DONE;
         SRI_DONE: nxt_state = SRI_IDLE;
         default: nxt_state = SRI_IDLE; // fourth code is illegal
      endcase
   end

   // state register
   // async clear so the block is idle straight out of reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) state_ff <= SRI_IDLE;
      else state_ff <= nxt_state;
   end

   // operands are frozen at acceptance so fetch may move on
   // latch instruction and count execution cycles
   // done costs one cycle, so exec runs cycles-1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_ff <= SRI_OP_NONE;
         cnt_ff <= 3'd0;
         len_ff <= 3'd0;
         ins_ff <= '0;
      end else if (take) begin
         op_ff <= dec.op;
         cnt_ff <= dec.cycles - 3'd1;
         len_ff <= dec.bytes;
         ins_ff <= instr;
      end else if (state_ff == SRI_EXEC && cnt_ff != 3'd0) begin
         cnt_ff <= cnt_ff - 3'd1;
      end
   end

   // result datapath
   // combinational, only used on the last execute cycle
   // carry defaults to the held flag for non-rotates
   always_comb begin
      res = ins_ff.dstData;
      resC = flags_ff[`SRI_FLAG_C];
      unique case (op_ff)
         SRI_OP_OR: res = ins_ff.dstData | ins_ff.srcData;
         SRI_OP_ROTL: begin
            res = {ins_ff.dstData[6:0], ins_ff.dstData[7]};
            resC = ins_ff.dstData[7];
         end
         SRI_OP_ROTLC: begin
            res = {ins_ff.dstData[6:0], flags_ff[`SRI_FLAG_C]};
            resC = ins_ff.dstData[7];
         end
         SRI_OP_ROTR: begin
            res = {ins_ff.dstData[0], ins_ff.dstData[7:1]};
            resC = ins_ff.dstData[0];
         end
         SRI_OP_ROTRC: begin
            res = {flags_ff[`SRI_FLAG_C], ins_ff.dstData[7:1]};
            resC = ins_ff.dstData[0];
         end
         default: res = ins_ff.dstData;
      endcase
   end

   // flag update on the last execute cycle
   // each op class owns its own set of flags; all others hold
   // V on rotates marks a change of the sign bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_ff <= `SRI_FLAGS_RST;
      end else if (lastCyc) begin
         unique case (op_ff)
            SRI_OP_OR: begin
               flags_ff[`SRI_FLAG_Z] <= (res == 8'h00);
               flags_ff[`SRI_FLAG_S] <= res[7];
               flags_ff[`SRI_FLAG_V] <= 1'b0;
            end
            SRI_OP_ROTL, SRI_OP_ROTLC, SRI_OP_ROTR, SRI_OP_ROTRC: begin
               flags_ff[`SRI_FLAG_C] <= resC;
               flags_ff[`SRI_FLAG_Z] <= (res == 8'h00);
               flags_ff[`SRI_FLAG_S] <= res[7];
               flags_ff[`SRI_FLAG_V] <= res[7] ^ ins_ff.dstData[7]; // sign change
            end
            SRI_OP_CCLR: flags_ff[`SRI_FLAG_C] <= 1'b0;
            default: flags_ff <= flags_ff; // stack ops keep all flags
         endcase
      end
   end

   // stack pointer: store pre-decrements, pull/exit post-increment
   // the store decrement lands at acceptance, so the write
   // that follows already addresses the new top of stack
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stkPtr_ff <= PTR_W'(`SRI_PTR_RST); // pointer reset value
      end else if (take && dec.op == SRI_OP_STORE) begin
         stkPtr_ff <= stkPtr_ff - PTR_W'(1);
      end else if (lastCyc && op_ff == SRI_OP_PULL) begin
         stkPtr_ff <= stkPtr_ff + PTR_W'(1);
      end else if (lastCyc && op_ff == SRI_OP_EXIT) begin
         stkPtr_ff <= stkPtr_ff + PTR_W'(2);
      end
   end

   // write port and program counter load, registered
   // strobes default low so each lasts exactly one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPort <= '0;
         pcLoad <= '0;
         pcLoadEn <= 1'b0;
      end else begin
         wrPort.en <= 1'b0;
         pcLoadEn <= 1'b0;
         if (lastCyc) begin
            unique case (op_ff)
               SRI_OP_STORE: begin
                  wrPort.en <= 1'b1;
                  wrPort.addr <= 12'(stkPtr_ff);
                  wrPort.data <= ins_ff.srcData;
               end
               SRI_OP_PULL: begin
                  wrPort.en <= 1'b1;
                  wrPort.addr <= ins_ff.dstAddr;
                  wrPort.data <= stackLo;
               end
               SRI_OP_EXIT: begin
                  pcLoadEn <= 1'b1;
                  pcLoad <= PC_W'({stackLo, stackHi});
               end
               SRI_OP_OR, SRI_OP_ROTL, SRI_OP_ROTLC, SRI_OP_ROTR, SRI_OP_ROTRC: begin
                  wrPort.en <= 1'b1;
                  wrPort.addr <= ins_ff.dstAddr;
                  wrPort.data <= res;
               end
               default: wrPort.en <= 1'b0;
            endcase
         end
      end
   end

   // illegal opcode pulse
   // registered, one cycle after the refused offer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) illegalOp <= 1'b0;
      else illegalOp <= instrValid && instrReady && !dec.legal;
   end

   // outputs straight from their registers
   assign stackPtr = stkPtr_ff;
   assign flags = flags_ff;
   // done pulses for the one cycle spent in the done state
   assign done = (state_ff == SRI_DONE);
   assign instrBytes = len_ff;
endmodule : sri_exec

// ==== src/sri_params.svh ====
// timing, opcode and layout constants for the stack/rotate executor
`ifndef SRI_PARAMS_SVH
`define SRI_PARAMS_SVH
// opcodes
`define SRI_OP_ORW_REG 8'h48
`define SRI_OP_ORW_IMM 8'h49
`define SRI_OP_POP_R 8'h50
`define SRI_OP_POP_IR 8'h51
`define SRI_OP_PULL_EXT 8'hD8
`define SRI_OP_PUSH_R 8'h70
`define SRI_OP_PUSH_IR 8'h71
`define SRI_OP_STORE_EXT 8'hC8
`define SRI_OP_CCLR 8'hCF
`define SRI_OP_RETN 8'hAF
`define SRI_OP_ROL_R 8'h90
`define SRI_OP_ROL_IR 8'h91
`define SRI_OP_ROLC_R 8'h10
`define SRI_OP_ROLC_IR 8'h11
`define SRI_OP_ROR_R 8'hE0
`define SRI_OP_ROR_IR 8'hE1
`define SRI_OP_RORC_R 8'hC0
`define SRI_OP_RORC_IR 8'hC1
// execution cycle counts
`define SRI_CYC_ORW 3'd3
`define SRI_CYC_PULL_EXT 3'd2
`define SRI_CYC_STORE_EXT 3'd2
`define SRI_CYC_SHORT_R 3'd2
`define SRI_CYC_SHORT_IR 3'd3
`define SRI_CYC_RETN 3'd4
`define SRI_CYC_CCLR 3'd2
// instruction byte counts
`define SRI_LEN_ORW 3'd4
`define SRI_LEN_X 3'd3
`define SRI_LEN_SHORT 3'd2
`define SRI_LEN_ONE 3'd1
// flag bit positions in the flags byte
`define SRI_FLAG_C 7
`define SRI_FLAG_Z 6
`define SRI_FLAG_S 5
`define SRI_FLAG_V 4
// reset values and maximum step count
`define SRI_PTR_RST 12'h000
`define SRI_FLAGS_RST 8'h00
`define SRI_STEP_MAX 3'd4
`endif

// ==== src/sri_pkg.sv ====
// types shared by the stack/rotate executor
package sri_pkg;
   // execution operation class
   typedef enum logic [3:0] {
      SRI_OP_NONE = 4'h0,
      SRI_OP_OR = 4'h1,
      SRI_OP_PULL = 4'h2,
      SRI_OP_STORE = 4'h3,
      SRI_OP_EXIT = 4'h4,
      SRI_OP_CCLR = 4'h5,
      SRI_OP_ROTL = 4'h6,
      SRI_OP_ROTLC = 4'h7,
      SRI_OP_ROTR = 4'h8,
      SRI_OP_ROTRC = 4'h9
   } sri_op_type;
   // executor state, gray along idle-exec-done
   typedef enum logic [1:0] {
      SRI_IDLE = 2'b00,
      SRI_EXEC = 2'b01,
      SRI_DONE = 2'b11
   } sri_state_type;
   // one instruction from fetch
   typedef struct packed {
      logic [7:0] opcode;
      logic [11:0] dstAddr;
      logic [7:0] srcData;
      logic [7:0] dstData;
   } sri_instr_type;
   // decode result
   typedef struct packed {
      sri_op_type op;
      logic legal;
      logic [2:0] cycles;
      logic [2:0] bytes;
   } sri_dec_type;
   // register file / memory write request
   typedef struct packed {
      logic en;
      logic [11:0] addr;
      logic [7:0] data;
   } sri_wr_type;
endpackage : sri_pkg

// ==== src/sri_decode.sv ====
// opcode decoder: operation class, cycle count and length
`timescale 1ns/1ps
`include "sri_params.svh"
module sri_decode (
   input wire logic [7:0] opcode,
   output sri_pkg::sri_dec_type dec
);
   import sri_pkg::*;

   // table lookup of the handled opcodes
   always_comb begin
      dec = '{op: SRI_OP_NONE, legal: 1'b0, cycles: 3'd0, bytes: 3'd0};
      unique case (opcode)
         `SRI_OP_ORW_REG, `SRI_OP_ORW_IMM: begin
            dec = '{SRI_OP_OR, 1'b1, `SRI_CYC_ORW, `SRI_LEN_ORW};
         end
         `SRI_OP_PULL_EXT: begin
            dec = '{SRI_OP_PULL, 1'b1, `SRI_CYC_PULL_EXT, `SRI_LEN_X};
         end
         `SRI_OP_POP_R: begin
            dec = '{SRI_OP_PULL, 1'b1, `SRI_CYC_SHORT_R, `SRI_LEN_SHORT};
         end
         `SRI_OP_POP_IR: begin
            dec = '{SRI_OP_PULL, 1'b1, `SRI_CYC_SHORT_IR, `SRI_LEN_SHORT};
         end
         `SRI_OP_STORE_EXT: begin
            dec = '{SRI_OP_STORE, 1'b1, `SRI_CYC_STORE_EXT, `SRI_LEN_X};
         end
         `SRI_OP_PUSH_R: begin
            dec = '{SRI_OP_STORE, 1'b1, `SRI_CYC_SHORT_R, `SRI_LEN_SHORT};
         end
         `SRI_OP_PUSH_IR: begin
            dec = '{SRI_OP_STORE, 1'b1, `SRI_CYC_SHORT_IR, `SRI_LEN_SHORT};
         end
         `SRI_OP_RETN: begin
            dec = '{SRI_OP_EXIT, 1'b1, `SRI_CYC_RETN, `SRI_LEN_ONE};
         end
         `SRI_OP_CCLR: begin
            dec = '{SRI_OP_CCLR, 1'b1, `SRI_CYC_CCLR, `SRI_LEN_ONE};
         end
         `SRI_OP_ROL_R, `SRI_OP_ROL_IR: begin
            dec = '{SRI_OP_ROTL, 1'b1, opcode[0] ? `SRI_CYC_SHORT_IR : `SRI_CYC_SHORT_R,
                    `SRI_LEN_SHORT};
         end
         `SRI_OP_ROLC_R, `SRI_OP_ROLC_IR: begin
            dec = '{SRI_OP_ROTLC, 1'b1, opcode[0] ? `SRI_CYC_SHORT_IR : `SRI_CYC_SHORT_R,
                    `SRI_LEN_SHORT};
         end
         `SRI_OP_ROR_R, `SRI_OP_ROR_IR: begin
            dec = '{SRI_OP_ROTR, 1'b1, opcode[0] ? `SRI_CYC_SHORT_IR : `SRI_CYC_SHORT_R,
                    `SRI_LEN_SHORT};
         end
         `SRI_OP_RORC_R, `SRI_OP_RORC_IR: begin
            dec = '{SRI_OP_ROTRC, 1'b1, opcode[0] ? `SRI_CYC_SHORT_IR : `SRI_CYC_SHORT_R,
                    `SRI_LEN_SHORT};
         end
         default: begin
            dec = '{op: SRI_OP_NONE, legal: 1'b0, cycles: 3'd0, bytes: 3'd0};
         end
      endcase
   end
endmodule : sri_decode

// ==== bench/sri_exec_chk.sv ====
// port assertions for the stack/rotate executor
`timescale 1ns/1ps
module sri_exec_chk #(
   parameter int PTR_W = 12,
   parameter int PC_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instrValid,
   input sri_pkg::sri_instr_type instr,
   input wire logic [7:0] stackLo,
   input wire logic [7:0] stackHi,
   input wire logic instrReady,
   input wire logic illegalOp,
   input sri_pkg::sri_wr_type wrPort,
   input wire logic [PTR_W-1:0] stackPtr,
   input wire logic [PC_W-1:0] pcLoad,
   input wire logic pcLoadEn,
   input wire logic [7:0] flags,
   input wire logic [2:0] instrBytes,
   input wire logic done
);
   import sri_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic take; // offer made while ready at this edge, legal or not
   logic [7:0] dstHold_ff; // operand at acceptance
   logic [7:0] flagHold_ff; // flags at acceptance
   logic [PTR_W-1:0] ptrHold_ff; // pointer at acceptance
   assign take = instrValid && instrReady;
   // freeze operands so later checks need no deep history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dstHold_ff <= 8'h00;
         flagHold_ff <= 8'h00;
         ptrHold_ff <= '0;
      end else if (take) begin
         dstHold_ff <= instr.dstData;
         flagHold_ff <= flags;
         ptrHold_ff <= stackPtr;
      end
   end
   chk_flags_move: assert property (!$stable(flags) |-> done)
      else $error("flags moved outside completion");
   chk_or_flags: assert property (take && instr.opcode == 8'h48 |-> ##3 done &&
      !flags[4] && flags[7] == flagHold_ff[7]) else $error("or flags wrong");
   chk_pull_ptr: assert property (take && instr.opcode == 8'hD8 |-> ##2 done &&
      wrPort.en && stackPtr == ptrHold_ff + PTR_W'(1)) else $error("pull pointer wrong");
   chk_store_addr: assert property (take && instr.opcode == 8'hC8 |-> ##2 wrPort.en &&
      wrPort.addr == 12'(ptrHold_ff - PTR_W'(1)) && flags == flagHold_ff)
      else $error("store address wrong");
   chk_exit_pc: assert property (take && instr.opcode == 8'hAF |-> ##4 pcLoadEn &&
      !wrPort.en && stackPtr == ptrHold_ff + PTR_W'(2)) else $error("exit wrong");
   chk_rot_left: assert property (take && instr.opcode == 8'h90 |-> ##2
      wrPort.data == {dstHold_ff[6:0], dstHold_ff[7]} && flags[7] == dstHold_ff[7])
      else $error("rotate left wrong");
   chk_rot_lcarry: assert property (take && instr.opcode == 8'h10 |-> ##2
      wrPort.data == {dstHold_ff[6:0], flagHold_ff[7]}) else $error("rotate left carry wrong");
   chk_rot_right: assert property (take && instr.opcode == 8'hE0 |-> ##2 done &&
      wrPort.data == {dstHold_ff[0], dstHold_ff[7:1]} && flags[7] == dstHold_ff[0])
      else $error("rotate right wrong");
   chk_rot_rcarry: assert property (take && instr.opcode == 8'hC0 |-> ##2
      wrPort.data == {flagHold_ff[7], dstHold_ff[7:1]}) else $error("rotate right carry wrong");
   chk_carry_clear: assert property (take && instr.opcode == 8'hCF |-> ##2 done &&
      flags == (flagHold_ff & 8'h7F)) else $error("carry clear wrong");
endmodule : sri_exec_chk
bind sri_exec sri_exec_chk #(.PTR_W(PTR_W), .PC_W(PC_W)) i_chk (.clk(clk), .rst_n(rst_n),
   .instrValid(instrValid), .instr(instr), .stackLo(stackLo), .stackHi(stackHi),
   .instrReady(instrReady), .illegalOp(illegalOp), .wrPort(wrPort), .stackPtr(stackPtr),
   .pcLoad(pcLoad), .pcLoadEn(pcLoadEn), .flags(flags), .instrBytes(instrBytes), .done(done));

// ==== bench/tb.sv ====
// self-checking bench for the stack/rotate executor
`timescale 1ns/1ps
module tb;
   import sri_pkg::*;
   logic clk = 1'b0; // 50 ns period
   logic rst_n = 1'b0;
   logic instrValid = 1'b0;
   sri_instr_type instr = '0;
   logic instrReady, illegalOp, pcLoadEn, done;
   sri_wr_type wrPort;
   logic [11:0] stackPtr;
   logic [15:0] pcLoad;
   logic [7:0] flags;
   logic [2:0] instrBytes;
   logic [7:0] mem [4096]; // model memory, fed to the stack inputs
   logic [11:0] ptrM = 12'h000; // model pointer
   logic [7:0] fM = 8'h00; // model flags
   int failures = 0;
   int num_checks = 0;
   int seed = 32'h2766;
   logic [7:0] opTab [18] = '{8'h48, 8'h49, 8'h50, 8'h51, 8'hD8, 8'h70, 8'h71, 8'hC8, 8'hCF,
      8'hAF, 8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1};
   always #25 clk = ~clk;
   sri_exec i_dut (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instr(instr),
      .stackLo(mem[stackPtr]), .stackHi(mem[stackPtr + 12'h001]), .instrReady(instrReady),
      .illegalOp(illegalOp), .wrPort(wrPort), .stackPtr(stackPtr), .pcLoad(pcLoad),
      .pcLoadEn(pcLoadEn), .flags(flags), .instrBytes(instrBytes), .done(done));
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   // one instruction through model and design
   task automatic exec(input logic [7:0] op);
      logic [7:0] s, d, r, f;
      logic [11:0] a, wa;
      logic [15:0] pc;
      logic we, rot;
      int n, cyc, len;
      s = 8'($random(seed));
      d = 8'($random(seed));
      a = 12'($random(seed));
      f = fM;
      wa = a;
      we = 1'b1;
      n = 0;
      pc = 16'h0000;
      r = d;
      rot = op inside {8'h90, 8'h91, 8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1};
      cyc = (op == 8'hAF) ? 4 : (op == 8'h48 || (op[0] && op != 8'hCF)) ? 3 : 2;
      len = (op[7:1] == 7'h24) ? 4 : (op == 8'hD8 || op == 8'hC8) ? 3 : op[3:0] == 4'hF ? 1 : 2;
      case (op)
         8'h48, 8'h49: begin
            r = d | s;
            f[6:4] = {r == 8'h00, r[7], 1'b0};
         end
         8'h50, 8'h51, 8'hD8: begin
            r = mem[ptrM];
            ptrM++;
         end
         8'h70, 8'h71, 8'hC8: begin
            ptrM--;
            wa = ptrM;
            r = s;
         end
         8'hCF: begin
            f[7] = 1'b0;
            we = 1'b0;
         end
         8'hAF: begin
            pc = {mem[ptrM], mem[ptrM + 12'h001]};
            ptrM = ptrM + 12'h002;
            we = 1'b0;
         end
         8'h90, 8'h91: r = {d[6:0], d[7]};
         8'h10, 8'h11: r = {d[6:0], fM[7]};
         8'hE0, 8'hE1: r = {d[0], d[7:1]};
         default: r = {fM[7], d[7:1]};
      endcase
      if (rot) f[7:4] = {op[6] ? d[0] : d[7], r == 8'h00, r[7], r[7] ^ d[7]};
      @(posedge clk);
      #1;
      instr = {op, a, s, d};
      instrValid = 1'b1;
      @(posedge clk);
      #1;
      instrValid = 1'b0;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (done !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      // n does not count the accepting edge, so one is added
      check(16'(n + 1), 16'(cyc), "cycles");
      check(16'(instrBytes), 16'(len), "length");
      check(wrPort.en, we, "write");
      if (we) begin
         check(wrPort.addr, wa, "addr");
         check(wrPort.data, r, "data");
         mem[wa] = r;
      end
      check(flags, f, "flags");
      check(stackPtr, ptrM, "pointer");
      check(pcLoadEn, op == 8'hAF, "pc strobe");
      if (op == 8'hAF) check(pcLoad, pc, "pc");
      fM = f;
   endtask : exec
   // main sequence
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'($random(seed));
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      foreach (opTab[k]) exec(opTab[k]);
      $display("test opcode sweep done");
      for (int k = 0; k < 60; k++) exec(opTab[$unsigned($random(seed)) % 18]);
      $display("test random mix done");
      @(posedge clk);
      #1;
      instr = {8'h00, 28'h0000000};
      instrValid = 1'b1;
      @(posedge clk);
      #1;
      instrValid = 1'b0;
      check(illegalOp, 1'b1, "illegal flag");
      check(instrReady, 1'b1, "ready after illegal");
      check(done, 1'b0, "done after illegal");
      $display("test illegal opcode done");
      rst_n = 1'b0;
      #1;
      check(stackPtr, 12'h000, "pointer in reset");
      check(flags, 8'h00, "flags in reset");
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      ptrM = 12'h000;
      fM = 8'h00;
      exec(8'hC8);
      exec(8'hD8);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : tb
